// ==== verilog/saa_pkg.sv ====
// Shared constants and types for the slave access arbitration pair.
// Assumes one clock at 40 MHz shared by both ends.
package saa_pkg;

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
localparam int DATA_W = 16;
localparam int ADDR_W = 6;
localparam int CLK_PERIOD_NS = 25;
localparam logic [2:0] BUSY_WAIT_MAX = 3'h4;
localparam logic [3:0] SEL_GAP_CYCLES = 4'h2;
localparam logic [3:0] MEM_HOLD_CYCLES = 4'h3;

// ----------------------------------------------------------------
// Synchroniser reset values and bit positions: select, memory request, strobe, style, acknowledge and ready
// ----------------------------------------------------------------
localparam logic [3:0] DEV_PIN_IDLE = 4'h3;
localparam logic [1:0] HOST_PIN_IDLE = 2'h3;
localparam int PIN_SEL = 0;
localparam int PIN_MEM = 1;
localparam int PIN_STB = 2;
localparam int PIN_STYLE = 3;
localparam int PIN_ACK = 0;
localparam int PIN_RDY = 1;

// ----------------------------------------------------------------
// Host command kinds and state types
// ----------------------------------------------------------------
localparam logic [1:0] CMD_REG_READ = 2'h0;
localparam logic [1:0] CMD_REG_WRITE = 2'h1;
localparam logic [1:0] CMD_MEM = 2'h2;

typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_MEM_WAIT = 3'b001,
    DEV_MEM_ACK = 3'b010,
    DEV_REG_WAIT = 3'b011,
    DEV_REG_ACK = 3'b100,
    DEV_SEL_WAIT = 3'b101,
    DEV_HOLDOFF = 3'b110,
    DEV_HOLD_REL = 3'b111
} saa_dev_state_type;

typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_SELECT = 3'b001,
    HST_WAIT_RDY = 3'b010,
    HST_WAIT_FREE = 3'b011,
    HST_GAP = 3'b100,
    HST_MEM_REQ = 3'b101,
    HST_MEM_HOLD = 3'b110
} saa_host_state_type;

endpackage

// ==== verilog/saa_if.sv ====
// Pin bundle between the host end and the device end.
// Assumes both ends run on the same clk; the data bus level is resolved here.
`timescale 1ns/100ps
`default_nettype none
interface saa_if;
    import saa_pkg::*;
    logic register_select_n;
    logic shared_memory_request_n;
    logic slave_address_strobe;
    logic slave_write_not_read;
    logic bus_style_select;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe;
    logic slave_memory_ack_n;
    logic slave_ready_out_n;
    logic [DATA_W-1:0] data_bus;

    // The wire reads zero when nobody drives it.
    assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);

    modport dev (
        input register_select_n, shared_memory_request_n, slave_address_strobe,
        input slave_write_not_read, bus_style_select, reg_addr, data_bus,
        output dev_data, dev_data_oe, slave_memory_ack_n, slave_ready_out_n
    );
    modport host (
        output register_select_n, shared_memory_request_n, slave_address_strobe,
        output slave_write_not_read, bus_style_select, reg_addr, host_data, host_data_oe,
        input data_bus, slave_memory_ack_n, slave_ready_out_n
    );
endinterface
`default_nettype wire

// ==== verilog/saa_dev.sv ====
// Device end: answers register accesses and shared memory requests.
// Assumes the host pins may change at any time relative to clk, and that
// the core answers register reads combinationally from reg_addr_out.
//
// Notes on behaviour
// [R1] Host never asserts select and memory request together.
// [R2] Two clocks between select and request swaps.
// [R3] Acknowledge low within one to five clocks.
// [R4] Select and request sampled asynchronously, then clocked.
// [R5] Memory acknowledge held until request released.
// [R6] Register acknowledge needs strobe; polarity by style.
// [R7] Register acknowledge ends when strobe goes inactive.
// [R8] Address and direction captured at strobe edge.
// [R9] Missed strobe: acknowledge held off until release.
// [R10] Register acknowledge zero to four clocks late.
// [R11] Host may raise strobe before select.
// [R12] Each strobe pulse under held select is one access.
// [R13] Select stays inactive at least one clock.
// [R14] Ready low during access, high on release.
// [R15] Read data driven, then floated on release.
// [R16] Early select release ends the whole cycle.
// [R17] Write data captured on a clock edge.
// [R18] Host inputs pass a multi-flop synchroniser; only select, request, strobe and style do here, not address, direction or data.
`timescale 1ns/100ps
`default_nettype none
module saa_dev (
    input wire logic clk,
    input wire logic nrst,
    saa_if.dev bus,
    input wire logic core_busy,
    input wire logic [saa_pkg::DATA_W-1:0] reg_rd_data,
    output logic [saa_pkg::ADDR_W-1:0] reg_addr_out,
    output logic [saa_pkg::DATA_W-1:0] reg_wr_data,
    output logic reg_wr_pulse,
    output logic reg_rd_pulse,
    output logic mem_grant
);
    import saa_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] pin_q;

    assign pin_raw = {bus.bus_style_select, bus.slave_address_strobe,
                      bus.shared_memory_request_n, bus.register_select_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            // A change counts once the second and third stages agree.
            always_ff @(posedge clk) begin // see [R4] see [R18]
                if (!nrst) begin
                    sync1_q[gi] <= DEV_PIN_IDLE[gi];
                    sync2_q[gi] <= DEV_PIN_IDLE[gi];
                    sync3_q[gi] <= DEV_PIN_IDLE[gi];
                    pin_q[gi] <= DEV_PIN_IDLE[gi];
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Decoded pin levels
    // ----------------------------------------------------------------
    wire sel_act = ~pin_q[PIN_SEL];
    wire mem_act = ~pin_q[PIN_MEM];
    // Strobe is active low in style 1 and active high in style 0.
    wire strobe_act = pin_q[PIN_STYLE] ? ~pin_q[PIN_STB] : pin_q[PIN_STB]; // see [R6]

    // ----------------------------------------------------------------
    // Access state machine
    // ----------------------------------------------------------------
    saa_dev_state_type state_q;
    saa_dev_state_type state_d;
    logic [2:0] wait_cnt_q;
    logic [2:0] wait_cnt_d;
    logic write_q;

    // A busy core delays the answer by at most BUSY_WAIT_MAX clocks.
    wire wait_done = ~core_busy | (wait_cnt_q == BUSY_WAIT_MAX); // see [R3] see [R10]
    wire in_wait = (state_q == DEV_MEM_WAIT) || (state_q == DEV_REG_WAIT);
    wire enter_reg = (state_q != DEV_REG_WAIT) && (state_d == DEV_REG_WAIT);
    wire enter_ack = (state_q == DEV_REG_WAIT) && (state_d == DEV_REG_ACK);
    wire reg_ack_d = (state_d == DEV_REG_ACK);
    wire mem_ack_d = (state_d == DEV_MEM_ACK);

    assign wait_cnt_d = (in_wait && !wait_done) ? wait_cnt_q + 3'h1 : 3'h0;

    always_comb begin
        state_d = state_q;
        case (state_q)
            DEV_IDLE: begin
                // Both requests at once is a host fault; neither is served.
                if (mem_act && !sel_act) begin // see [R1]
                    state_d = DEV_MEM_WAIT;
                end else if (sel_act && !mem_act) begin
                    if (strobe_act) begin // see [R11]
                        state_d = DEV_REG_WAIT;
                    end else begin
                        state_d = DEV_HOLDOFF; // see [R9]
                    end
                end
            end
            DEV_MEM_WAIT: begin
                if (!mem_act) begin
                    state_d = DEV_IDLE;
                end else if (wait_done) begin
                    state_d = DEV_MEM_ACK;
                end
            end
            DEV_MEM_ACK: begin
                // Only the request ends a memory grant.
                if (!mem_act) begin // see [R5]
                    state_d = DEV_IDLE;
                end
            end
            DEV_REG_WAIT: begin
                if (!sel_act) begin
                    state_d = DEV_IDLE; // see [R16]
                end else if (!strobe_act) begin
                    state_d = DEV_SEL_WAIT;
                end else if (wait_done) begin
                    state_d = DEV_REG_ACK;
                end
            end
            DEV_REG_ACK: begin
                if (!sel_act) begin
                    state_d = DEV_IDLE; // see [R16]
                end else if (!strobe_act) begin
                    state_d = DEV_SEL_WAIT; // see [R7]
                end
            end
            DEV_SEL_WAIT: begin
                // Select held: the next strobe pulse is a fresh access.
                if (!sel_act) begin
                    state_d = DEV_IDLE;
                end else if (strobe_act) begin
                    state_d = DEV_REG_WAIT; // see [R12]
                end
            end
            DEV_HOLDOFF: begin
                if (!sel_act) begin
                    state_d = DEV_IDLE;
                end else if (strobe_act) begin
                    state_d = DEV_HOLD_REL; // see [R9]
                end
            end
            DEV_HOLD_REL: begin
                // A late strobe gets no answer until it is released.
                if (!sel_act) begin
                    state_d = DEV_IDLE;
                end else if (!strobe_act) begin
                    state_d = DEV_SEL_WAIT; // see [R9]
                end
            end
            default: begin
                state_d = DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= DEV_IDLE;
            wait_cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            wait_cnt_q <= wait_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Capture of address, direction and data
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_addr_out <= '0;
            write_q <= 1'b0;
        end else if (enter_reg) begin
            reg_addr_out <= bus.reg_addr; // see [R8]
            write_q <= bus.slave_write_not_read; // see [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_wr_data <= '0;
            bus.dev_data <= '0;
        end else if (enter_ack) begin
            reg_wr_data <= bus.data_bus; // see [R17]
            bus.dev_data <= reg_rd_data; // see [R15]
        end
    end

    // ----------------------------------------------------------------
    // Pin and core outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.slave_memory_ack_n <= 1'b1;
            bus.slave_ready_out_n <= 1'b1;
            bus.dev_data_oe <= 1'b0;
            reg_wr_pulse <= 1'b0;
            reg_rd_pulse <= 1'b0;
            mem_grant <= 1'b0;
        end else begin
            bus.slave_memory_ack_n <= ~(reg_ack_d | mem_ack_d); // see [R3] see [R5] see [R7]
            bus.slave_ready_out_n <= ~reg_ack_d; // see [R14]
            bus.dev_data_oe <= reg_ack_d & ~write_q; // see [R15]
            reg_wr_pulse <= enter_ack & write_q; // see [R17]
            reg_rd_pulse <= enter_ack & ~write_q;
            mem_grant <= mem_ack_d;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/saa_host.sv ====
// Host end: turns user commands into register and shared memory cycles.
// Assumes cfg_style is static and the device end shares clk.
`timescale 1ns/100ps
`default_nettype none
module saa_host (
    input wire logic clk,
    input wire logic nrst,
    saa_if.host bus,
    input wire logic cfg_style,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_kind,
    input wire logic [saa_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [saa_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [saa_pkg::DATA_W-1:0] rsp_rdata
);
    import saa_pkg::*;

    // ----------------------------------------------------------------
    // Answer synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pin_raw;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] pin_q;

    assign pin_raw = {bus.slave_ready_out_n, bus.slave_memory_ack_n};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    sync1_q[gi] <= HOST_PIN_IDLE[gi];
                    sync2_q[gi] <= HOST_PIN_IDLE[gi];
                    sync3_q[gi] <= HOST_PIN_IDLE[gi];
                    pin_q[gi] <= HOST_PIN_IDLE[gi];
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    wire ack_low = ~pin_q[PIN_ACK];
    wire rdy_low = ~pin_q[PIN_RDY];

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    saa_host_state_type state_q;
    saa_host_state_type state_d;
    logic [3:0] cnt_q;
    logic strobe_q;
    logic strobe_d;
    logic sel_n_d;
    logic shared_memory_request_n_n_d;
    logic oe_d;
    logic rsp_d;

    wire start = (state_q == HST_IDLE) && cmd_valid;
    wire is_mem = (cmd_kind == CMD_MEM);
    wire gap_done = (cnt_q >= SEL_GAP_CYCLES); // see [R2] see [R13]
    wire hold_done = (cnt_q >= MEM_HOLD_CYCLES);

    always_comb begin
        state_d = state_q;
        strobe_d = strobe_q;
        sel_n_d = bus.register_select_n;
        shared_memory_request_n_n_d = bus.shared_memory_request_n;
        oe_d = bus.host_data_oe;
        rsp_d = 1'b0;
        case (state_q)
            HST_IDLE: begin
                if (cmd_valid && is_mem) begin
                    shared_memory_request_n_n_d = 1'b0;
                    state_d = HST_MEM_REQ;
                end else if (cmd_valid) begin
                    // Strobe leads select by one clock.
                    strobe_d = 1'b1; // see [R11]
                    oe_d = (cmd_kind == CMD_REG_WRITE);
                    state_d = HST_SELECT;
                end
            end
            HST_SELECT: begin
                sel_n_d = 1'b0;
                state_d = HST_WAIT_RDY;
            end
            HST_WAIT_RDY: begin
                if (rdy_low) begin
                    strobe_d = 1'b0;
                    sel_n_d = 1'b1;
                    oe_d = 1'b0;
                    rsp_d = 1'b1;
                    state_d = HST_WAIT_FREE;
                end
            end
            HST_WAIT_FREE: begin
                if (!ack_low && !rdy_low) begin
                    state_d = HST_GAP;
                end
            end
            HST_GAP: begin
                if (gap_done) begin // see [R1] see [R2] see [R13]
                    state_d = HST_IDLE;
                end
            end
            HST_MEM_REQ: begin
                if (ack_low) begin
                    state_d = HST_MEM_HOLD;
                end
            end
            HST_MEM_HOLD: begin
                if (hold_done) begin
                    shared_memory_request_n_n_d = 1'b1;
                    rsp_d = 1'b1;
                    state_d = HST_WAIT_FREE;
                end
            end
            default: begin
                state_d = HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= HST_IDLE;
            cnt_q <= 4'h0;
            strobe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d == state_q) ? cnt_q + 4'h1 : 4'h0;
            strobe_q <= strobe_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bus.register_select_n <= 1'b1;
            bus.shared_memory_request_n <= 1'b1;
            bus.slave_address_strobe <= 1'b0;
            bus.slave_write_not_read <= 1'b0;
            bus.bus_style_select <= 1'b0;
            bus.reg_addr <= '0;
            bus.host_data <= '0;
            bus.host_data_oe <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            bus.register_select_n <= sel_n_d;
            bus.shared_memory_request_n <= shared_memory_request_n_n_d;
            bus.slave_address_strobe <= cfg_style ? ~strobe_d : strobe_d;
            bus.bus_style_select <= cfg_style;
            bus.host_data_oe <= oe_d;
            cmd_ready <= (state_d == HST_IDLE) && !start;
            rsp_valid <= rsp_d;
            if (start) begin
                bus.reg_addr <= cmd_addr;
                bus.slave_write_not_read <= (cmd_kind == CMD_REG_WRITE);
                bus.host_data <= cmd_wdata;
            end
            if (state_q == HST_WAIT_RDY && rdy_low) begin
                rsp_rdata <= bus.data_bus;
            end
        end
    end

endmodule
`default_nettype wire

// ==== tb/saa_asserts.sv ====
// Concurrent checks on the pins between the host end and the device end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/100ps
`default_nettype none
module saa_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic register_select_n,
    input wire logic shared_memory_request_n,
    input wire logic slave_address_strobe,
    input wire logic slave_write_not_read,
    input wire logic bus_style_select,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic slave_memory_ack_n,
    input wire logic slave_ready_out_n
);
    logic stb_on;

    // Strobe level folded to active high for either bus style.
    assign stb_on = bus_style_select ? !slave_address_strobe : slave_address_strobe;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // Host side of the pins
    // ----------------------------------------------------------------
    AST_NO_OVERLAP: assert property (register_select_n || shared_memory_request_n)
        else $error("select and request together");
    AST_SWAP_GAP: assert property (($rose(register_select_n) || $rose(shared_memory_request_n))
        |=> (register_select_n && shared_memory_request_n) [*2])
        else $error("no gap after a release");
    AST_STB_FIRST: assert property ($fell(register_select_n) |-> stb_on)
        else $error("select without a strobe");

    // ----------------------------------------------------------------
    // Device side of the pins
    // ----------------------------------------------------------------
    AST_SYNC_DELAY: assert property (($fell(register_select_n) || $fell(shared_memory_request_n))
        |-> slave_memory_ack_n [*3])
        else $error("acknowledge too early");
    AST_MEM_ACK_TIME: assert property ($fell(shared_memory_request_n) |-> ##[3:12] !slave_memory_ack_n)
        else $error("memory acknowledge late");
    AST_MEM_ACK_HOLD: assert property (!slave_memory_ack_n && !shared_memory_request_n
        |=> !slave_memory_ack_n)
        else $error("memory acknowledge dropped");
    AST_MEM_ACK_END: assert property ($rose(shared_memory_request_n) |-> ##[1:8] slave_memory_ack_n)
        else $error("memory acknowledge not released");
    AST_REG_ACK_TIME: assert property ($fell(register_select_n) |-> ##[3:14] !slave_memory_ack_n)
        else $error("register acknowledge late");
    AST_REG_ACK_CAUSE: assert property ($fell(slave_memory_ack_n) && shared_memory_request_n
        |-> stb_on && !register_select_n)
        else $error("acknowledge without strobe");
    AST_REG_RELEASE: assert property ($fell(stb_on) && shared_memory_request_n
        |-> ##[1:8] (slave_memory_ack_n && slave_ready_out_n && !dev_data_oe))
        else $error("register cycle not ended");
    AST_READY_PAIR: assert property (!slave_ready_out_n
        |-> !slave_memory_ack_n && shared_memory_request_n)
        else $error("ready low outside access");
    AST_READ_DRIVE: assert property (dev_data_oe
        |-> !slave_write_not_read && !host_data_oe && !slave_ready_out_n)
        else $error("data driven outside a read");

    cover property (!slave_memory_ack_n && !shared_memory_request_n);
    cover property (dev_data_oe && !slave_ready_out_n);
    cover property (host_data_oe && !slave_memory_ack_n);
endmodule
`default_nettype wire

// ==== tb/saa_tb_top.sv ====
// Self-checking bench: host end and device end joined by the pin bundle.
// Assumes the package, interface and both ends are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module saa_tb_top;
    import saa_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_style = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_kind = CMD_REG_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic core_busy = 1'b0;
    logic cmd_ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic [DATA_W-1:0] rd_data;
    logic [ADDR_W-1:0] core_addr;
    logic [DATA_W-1:0] core_wdata;
    logic wr_pulse;
    logic rd_pulse;
    logic mem_grant;
    logic f_rd_pulse;
    logic hit;
    logic [DATA_W-1:0] core_regs [64];
    int wr_count = 0;
    int rd_count = 0;
    int f_rd_count = 0;
    int grant_cycles = 0;
    int g0;
    int miscompares = 0;
    int tests_run = 0;

    // ----------------------------------------------------------------
    // Ends, fault end and checker
    // ----------------------------------------------------------------
    saa_if bus_if();
    saa_if bad_if();
    saa_host saa_host_i (.clk(clk), .nrst(nrst), .bus(bus_if.host), .cfg_style(cfg_style), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    saa_dev saa_dev_i (.clk(clk), .nrst(nrst), .bus(bus_if.dev), .core_busy(core_busy), .reg_rd_data(rd_data),
        .reg_addr_out(core_addr), .reg_wr_data(core_wdata), .reg_wr_pulse(wr_pulse), .reg_rd_pulse(rd_pulse),
        .mem_grant(mem_grant));
    saa_dev saa_dev_fault_i (.clk(clk), .nrst(nrst), .bus(bad_if.dev), .core_busy(1'b0), .reg_rd_data(16'h5A5A),
        .reg_addr_out(), .reg_wr_data(), .reg_wr_pulse(), .reg_rd_pulse(f_rd_pulse), .mem_grant());
    saa_asserts saa_asserts_i (.clk(clk), .nrst(nrst), .register_select_n(bus_if.register_select_n),
        .shared_memory_request_n(bus_if.shared_memory_request_n), .slave_address_strobe(bus_if.slave_address_strobe),
        .slave_write_not_read(bus_if.slave_write_not_read), .bus_style_select(bus_if.bus_style_select),
        .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe),
        .slave_memory_ack_n(bus_if.slave_memory_ack_n), .slave_ready_out_n(bus_if.slave_ready_out_n));

    // ----------------------------------------------------------------
    // Clock and core register model
    // ----------------------------------------------------------------
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    assign rd_data = core_regs[core_addr];
    always @(posedge clk) begin
        if (wr_pulse === 1'b1) begin
            core_regs[core_addr] <= core_wdata;
            wr_count++;
        end
        if (rd_pulse === 1'b1) rd_count++;
        if (f_rd_pulse === 1'b1) f_rd_count++;
        if (mem_grant === 1'b1) grant_cycles++;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic do_reset(input logic style);
        nrst <= 1'b0;
        cfg_style <= style;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic run_cmd(input logic [1:0] kind, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 300);
        cmd_kind <= kind;
        cmd_addr <= addr;
        cmd_wdata <= wdata;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 300);
    endtask

    task automatic wait_ack(input logic lvl, input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if (bad_if.slave_memory_ack_n === lvl) seen = 1'b1;
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 64; i++) core_regs[i] = 16'hC3A0 ^ 16'(i);
        bad_if.register_select_n <= 1'b1;
        bad_if.shared_memory_request_n <= 1'b1;
        bad_if.slave_address_strobe <= 1'b0;
        bad_if.slave_write_not_read <= 1'b0;
        bad_if.bus_style_select <= 1'b0;
        bad_if.reg_addr <= '0;
        bad_if.host_data <= '0;
        bad_if.host_data_oe <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            run_cmd(CMD_REG_WRITE, 6'h3F, 16'hBEEF ^ 16'(s));
            `CHECK(core_regs[6'h3F], 16'hBEEF ^ 16'(s))
            run_cmd(CMD_REG_READ, 6'h3F, 16'h0000);
            `CHECK(rsp_rdata, 16'hBEEF ^ 16'(s))
            core_busy <= 1'b1;
            run_cmd(CMD_REG_READ, 6'h00, 16'h0000);
            `CHECK(rsp_rdata, 16'hC3A0)
            core_busy <= 1'b0;
            g0 = grant_cycles;
            run_cmd(CMD_MEM, 6'h00, 16'h0000);
            `CHECK(grant_cycles - g0 >= int'(MEM_HOLD_CYCLES), 1'b1)
        end
        `CHECK(wr_count, 2)
        `CHECK(rd_count, 4)
        @(posedge clk);
        bad_if.register_select_n <= 1'b0;
        bad_if.shared_memory_request_n <= 1'b0;
        bad_if.slave_address_strobe <= 1'b1;
        wait_ack(1'b0, 16, hit);
        `CHECK(hit, 1'b0)
        bad_if.register_select_n <= 1'b1;
        bad_if.shared_memory_request_n <= 1'b1;
        bad_if.slave_address_strobe <= 1'b0;
        repeat (8) @(posedge clk);
        bad_if.register_select_n <= 1'b0;
        repeat (8) @(posedge clk);
        bad_if.slave_address_strobe <= 1'b1;
        wait_ack(1'b0, 12, hit);
        `CHECK(hit, 1'b0)
        bad_if.slave_address_strobe <= 1'b0;
        repeat (6) @(posedge clk);
        bad_if.slave_address_strobe <= 1'b1;
        wait_ack(1'b0, 14, hit);
        `CHECK(hit, 1'b1)
        `CHECK(bad_if.slave_ready_out_n, 1'b0)
        `CHECK(bad_if.data_bus, 16'h5A5A)
        bad_if.slave_address_strobe <= 1'b0;
        wait_ack(1'b1, 8, hit);
        `CHECK(hit, 1'b1)
        `CHECK(bad_if.dev_data_oe, 1'b0)
        bad_if.slave_address_strobe <= 1'b1;
        wait_ack(1'b0, 14, hit);
        `CHECK(hit, 1'b1)
        bad_if.register_select_n <= 1'b1;
        wait_ack(1'b1, 8, hit);
        `CHECK(hit, 1'b1)
        `CHECK(bad_if.slave_ready_out_n, 1'b1)
        bad_if.slave_address_strobe <= 1'b0;
        `CHECK(f_rd_count, 2)
        final_report();
    end

    initial begin
        repeat (6000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
